// *** common/wake_flags_pkg.sv ***
/*
  Constants for the wake and interrupt flag block: register byte
  addresses, field positions, reset values and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus, one register per word.
*/
package wake_flags_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] FLAG_REG_ADDR   = 16'h00e8;
  localparam logic [15:0] LEVEL_REG_ADDR  = 16'h00f8;
  localparam logic [15:0] ENABLE_REG_ADDR = 16'h20b0;
  localparam logic [15:0] MASK_REG_ADDR   = 16'h2100;
  localparam logic [15:0] STATUS_REG_ADDR = 16'h2104;

  // ----------------------------------------------------------------
  // Flag register fields
  // ----------------------------------------------------------------
  localparam int XFER_BIT  = 0;
  localparam int SEC_BIT   = 1;
  localparam int COLA_BIT  = 2;
  localparam int COLB_BIT  = 3;
  localparam int BTN_BIT   = 4;
  localparam int WAKE_BIT  = 5;
  localparam int RISE_BIT  = 6;
  localparam int FALL_BIT  = 7;

  // ----------------------------------------------------------------
  // Enable register fields
  // ----------------------------------------------------------------
  localparam int WDOG_EN_BIT = 0;
  localparam int SPI_EN_BIT  = 4;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int LEVEL_W = 7;
  localparam int EVENT_W = 8;
  localparam logic [7:0] FLAG_RESET   = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : wake_flags_pkg

// *** logic/sync_edge.sv ***
/*
  Two-flop synchroniser with rise and fall pulses for a vector of
  asynchronous inputs. Assumes one clock and a synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module sync_edge #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // Edges look only at the second and third stage
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o  = sync_r & ~prev_r;
  assign fall_o  = ~sync_r & prev_r;

endmodule // sync_edge

`default_nettype wire

// *** logic/wake_and_interrupt_flags.sv ***
/*
  Wake-source and interrupt flag logic with an AXI4-Lite register
  slave. Assumes pin inputs are asynchronous to sys_clk_i; power-mode
  requests and event pulses come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - A rising edge on the push-button input sets the button flag.
// - The button flag holds until firmware writes a zero to it.
// - A sleep or display-only mode request clears the button flag.
// - Power-good rising sets the rise flag and raises the power line.
// - Power-good falling sets the fall flag, raises the line, browns out.
// - A direct wake into brownout by button or timer leaves fall clear.
// - An autowake timer wake sets the wake flag until written zero.
// - Transfer and one-second flags follow hardware and self-clear.
// - Two firmware collision flags sit at flag bits 2 and 3, read/write.
// - Enable bit 0 gates watchdog near-overflow, bit 4 gates serial port.
// - The level field shows the live external interrupt inputs 0 to 6.
module wake_and_interrupt_flags (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // AXI4-Lite slave
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins and events
  input  wire logic        push_button_input_i,
  input  wire logic        pll_locked_i,
  input  wire logic [6:0]  ext_irq_i,
  input  wire logic        autowake_event_i,
  input  wire logic        transfer_busy_event_i,
  input  wire logic        one_second_event_i,
  input  wire logic        fw_collision_a_event_i,
  input  wire logic        fw_collision_b_event_i,
  input  wire logic        watchdog_near_overflow_i,
  input  wire logic        serial_port_irq_i,
  input  wire logic        sleep_request_i,
  input  wire logic        display_request_i,
  input  wire logic        direct_brownout_wake_i,
  // Core side
  output logic             power_interrupt_line_o,
  output logic             brownout_request_o,
  output logic             core_irq_o,
  output logic             irq_o
);

  import wake_flags_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] pin_level;
  logic [8:0] pin_rise;
  logic [8:0] pin_fall;

  sync_edge #(
    .W (9)
  ) u_pins (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({pll_locked_i, push_button_input_i, ext_irq_i}),
    .level_o   (pin_level),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  logic button_rise;
  logic power_rise;
  logic power_fall;

  // Pin order: bit 8 power good, bit 7 button, bits 6:0 levels
  assign button_rise = pin_rise[7];
  assign power_rise  = pin_rise[8];
  assign power_fall  = pin_fall[8];

  // ----------------------------------------------------------------
  // Bus handshake state
  // ----------------------------------------------------------------
  logic        aw_held_r,  aw_held_nxt;
  logic        w_held_r,   w_held_nxt;
  logic [15:0] aw_addr_r,  aw_addr_nxt;
  logic [31:0] w_data_r,   w_data_nxt;
  logic        w_lane0_r,  w_lane0_nxt;
  logic        bvalid_r,   bvalid_nxt;
  logic [1:0]  bresp_r,    bresp_nxt;
  logic        rvalid_r,   rvalid_nxt;
  logic [31:0] rdata_r,    rdata_nxt;
  logic [1:0]  rresp_r,    rresp_nxt;
  logic        awready_r,  awready_nxt;
  logic        wready_r,   wready_nxt;
  logic        arready_r,  arready_nxt;

  logic        wr_fire;
  logic        rd_fire;
  logic        wr_flag;
  logic        wr_enable;
  logic        wr_mask;
  logic        rd_status;

  assign wr_fire   = aw_held_r & w_held_r & ~bvalid_r;
  assign rd_fire   = s_axi_arvalid & arready_r;
  assign wr_flag   = wr_fire & w_lane0_r & (aw_addr_r == FLAG_REG_ADDR);
  assign wr_enable = wr_fire & w_lane0_r & (aw_addr_r == ENABLE_REG_ADDR);
  assign wr_mask   = wr_fire & w_lane0_r & (aw_addr_r == MASK_REG_ADDR);
  assign rd_status = rd_fire & (s_axi_araddr == STATUS_REG_ADDR);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] flag_r,   flag_nxt;
  logic [7:0] enable_r, enable_nxt;
  logic [7:0] mask_r,   mask_nxt;
  logic [7:0] status_r, status_nxt;
  logic       pwr_line_r, pwr_line_nxt;
  logic       brown_r,  brown_nxt;
  logic       core_irq_r, core_irq_nxt;
  logic       irq_r,    irq_nxt;
  logic [7:0] wbyte;
  logic [7:0] events;

  assign wbyte = w_data_r[7:0];

  always_comb begin
    flag_nxt = flag_r;
    if (wr_flag) begin
      flag_nxt[BTN_BIT]  = flag_r[BTN_BIT]  & wbyte[BTN_BIT];
      flag_nxt[WAKE_BIT] = flag_r[WAKE_BIT] & wbyte[WAKE_BIT];
      flag_nxt[RISE_BIT] = flag_r[RISE_BIT] & wbyte[RISE_BIT];
      flag_nxt[FALL_BIT] = flag_r[FALL_BIT] & wbyte[FALL_BIT];
      flag_nxt[COLA_BIT] = wbyte[COLA_BIT];
      flag_nxt[COLB_BIT] = wbyte[COLB_BIT];
    end
    if (sleep_request_i || display_request_i) begin
      flag_nxt[BTN_BIT] = 1'b0;
    end
    // Button edge sets, wins over clears
    if (button_rise) begin
      flag_nxt[BTN_BIT] = 1'b1;
    end
    if (autowake_event_i) begin
      flag_nxt[WAKE_BIT] = 1'b1;
    end
    if (power_rise) begin
      flag_nxt[RISE_BIT] = 1'b1;
    end
    // Fall sets unless direct brownout wake
    if (power_fall && !direct_brownout_wake_i) begin
      flag_nxt[FALL_BIT] = 1'b1;
    end
    if (fw_collision_a_event_i) begin
      flag_nxt[COLA_BIT] = 1'b1;
    end
    if (fw_collision_b_event_i) begin
      flag_nxt[COLB_BIT] = 1'b1;
    end
    flag_nxt[XFER_BIT] = transfer_busy_event_i;
    flag_nxt[SEC_BIT]  = one_second_event_i;
  end

  always_comb begin
    enable_nxt = enable_r;
    if (wr_enable) begin
      enable_nxt = wbyte;
    end
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = wbyte;
    end
  end

  // Sticky block events; read clears, a new event wins
  assign events = {power_fall, power_rise, autowake_event_i, button_rise,
                   fw_collision_b_event_i, fw_collision_a_event_i,
                   one_second_event_i, transfer_busy_event_i};

  always_comb begin
    status_nxt = status_r;
    if (rd_status) begin
      status_nxt = STATUS_RESET;
    end
    status_nxt = status_nxt | events;
    irq_nxt = |(status_nxt & mask_r);
  end

  always_comb begin
    // Power line while a power flag stands
    pwr_line_nxt = flag_nxt[RISE_BIT] | flag_nxt[FALL_BIT];
    brown_nxt = brown_r;
    if (power_fall) begin
      brown_nxt = 1'b1;
    end else if (power_rise) begin
      brown_nxt = 1'b0;
    end
    core_irq_nxt = (|flag_nxt[FALL_BIT:COLA_BIT])
                 | flag_nxt[XFER_BIT] | flag_nxt[SEC_BIT]
                 | (watchdog_near_overflow_i & enable_nxt[WDOG_EN_BIT])
                 | (serial_port_irq_i & enable_nxt[SPI_EN_BIT]);
  end

  // ----------------------------------------------------------------
  // Bus channel logic
  // ----------------------------------------------------------------
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_data_nxt  = w_data_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt  = 1'b1;
      w_data_nxt  = s_axi_wdata;
      w_lane0_nxt = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      // Unmapped or read-only targets answer with an error
      if (aw_addr_r == FLAG_REG_ADDR || aw_addr_r == ENABLE_REG_ADDR ||
          aw_addr_r == MASK_REG_ADDR) begin
        bresp_nxt = RESP_OKAY;
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Accept one of each, then stall until the response is taken
    awready_nxt = ~aw_held_nxt & ~bvalid_nxt & ~(s_axi_awvalid & awready_r);
    wready_nxt  = ~w_held_nxt & ~bvalid_nxt & ~(s_axi_wvalid & wready_r);
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case (s_axi_araddr)
        FLAG_REG_ADDR:   rdata_nxt = {24'h00_0000, flag_r};
        LEVEL_REG_ADDR:  rdata_nxt = {25'h000_0000, pin_level[6:0]};
        ENABLE_REG_ADDR: rdata_nxt = {24'h00_0000, enable_r};
        MASK_REG_ADDR:   rdata_nxt = {24'h00_0000, mask_r};
        STATUS_REG_ADDR: rdata_nxt = {24'h00_0000, status_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = ~rvalid_nxt & ~rd_fire;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      flag_r       <= FLAG_RESET;
      enable_r     <= ENABLE_RESET;
      mask_r       <= MASK_RESET;
      status_r     <= STATUS_RESET;
      pwr_line_r   <= 1'b0;
      brown_r      <= 1'b0;
      core_irq_r   <= 1'b0;
      irq_r        <= 1'b0;
      aw_held_r    <= 1'b0;
      aw_addr_r    <= 16'h0000;
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_lane0_r    <= 1'b0;
      bvalid_r     <= 1'b0;
      bresp_r      <= RESP_OKAY;
      rvalid_r     <= 1'b0;
      rdata_r      <= 32'h0000_0000;
      rresp_r      <= RESP_OKAY;
      awready_r    <= 1'b0;
      wready_r     <= 1'b0;
      arready_r    <= 1'b0;
    end else begin
      flag_r       <= flag_nxt;
      enable_r     <= enable_nxt;
      mask_r       <= mask_nxt;
      status_r     <= status_nxt;
      pwr_line_r   <= pwr_line_nxt;
      brown_r      <= brown_nxt;
      core_irq_r   <= core_irq_nxt;
      irq_r        <= irq_nxt;
      aw_held_r    <= aw_held_nxt;
      aw_addr_r    <= aw_addr_nxt;
      w_held_r     <= w_held_nxt;
      w_data_r     <= w_data_nxt;
      w_lane0_r    <= w_lane0_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
      awready_r    <= awready_nxt;
      wready_r     <= wready_nxt;
      arready_r    <= arready_nxt;
    end
  end

  assign s_axi_awready          = awready_r;
  assign s_axi_wready           = wready_r;
  assign s_axi_bvalid           = bvalid_r;
  assign s_axi_bresp            = bresp_r;
  assign s_axi_arready          = arready_r;
  assign s_axi_rvalid           = rvalid_r;
  assign s_axi_rdata            = rdata_r;
  assign s_axi_rresp            = rresp_r;
  assign power_interrupt_line_o = pwr_line_r;
  assign brownout_request_o     = brown_r;
  assign core_irq_o             = core_irq_r;
  assign irq_o                  = irq_r;

endmodule // wake_and_interrupt_flags

`default_nettype wire

// *** tb/wake_flags_monitor.sv ***
/*
  Checker for the wake and interrupt flag block, bound to its top.
  Assumes pins are held steady for several cycles around edges.
*/
`timescale 1ns/1ps
`default_nettype none

module wake_flags_monitor (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pll_locked_i,
  input wire logic        direct_brownout_wake_i,
  input wire logic        transfer_busy_event_i,
  input wire logic        power_interrupt_line_o,
  input wire logic        brownout_request_o,
  input wire logic        core_irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // --------
  // Bus
  // --------
  a_bvalid_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  // --------
  // Flags
  // --------
  a_rise_line: assert property (
    $rose(pll_locked_i) |-> ##[3:6] power_interrupt_line_o)
    else $error("power line missing after rise");
  a_fall_brownout: assert property (
    $fell(pll_locked_i) && !direct_brownout_wake_i
    |-> ##[3:6] brownout_request_o && power_interrupt_line_o)
    else $error("brownout missing after fall");
  a_xfer_irq: assert property (
    $rose(transfer_busy_event_i) |-> ##[1:2] core_irq_o)
    else $error("core irq missing for transfer flag");
endmodule // wake_flags_monitor

bind wake_and_interrupt_flags wake_flags_monitor mon_u (.*);

`default_nettype wire

// *** tb/wake_and_interrupt_flags_tb_top.sv ***
/*
  Self-checking bench for the wake and interrupt flag block.
  Assumes the package constants and the AXI4-Lite slave timing.
*/
`timescale 1ns/1ps
`default_nettype none

module wake_and_interrupt_flags_tb_top;
  import wake_flags_pkg::*;
  logic        sys_clk_i, rst_b_i, s_axi_awvalid, s_axi_wvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        push_button_input_i, pll_locked_i, autowake_event_i;
  logic [6:0]  ext_irq_i, lv;
  logic        transfer_busy_event_i, one_second_event_i;
  logic        fw_collision_a_event_i, fw_collision_b_event_i;
  logic        watchdog_near_overflow_i, serial_port_irq_i;
  logic        sleep_request_i, display_request_i;
  logic        direct_brownout_wake_i, power_interrupt_line_o;
  logic        brownout_request_o, core_irq_o, irq_o;
  logic [7:0]  wv;
  integer      seed, err_total, tests_run, cyc_cnt;
  logic [15:0] regs [5] = '{FLAG_REG_ADDR, LEVEL_REG_ADDR,
    ENABLE_REG_ADDR, MASK_REG_ADDR, STATUS_REG_ADDR};

  wake_and_interrupt_flags dut_u (.*);

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] bit_of(input int b);
    return 32'h0000_0001 << b;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Handshakes are sampled at the rising edge, as the slave sees them
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    logic ta, tw;
    logic [1:0] r;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready && s_axi_awvalid) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ta && tw));
    do begin
      @(posedge sys_clk_i);
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(r), 32'(er));
  endtask

  task automatic rc(input logic [15:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge sys_clk_i);
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("rdata", d, e);
    chk("rresp", 32'(r), 32'(er));
  endtask

  // Hang guard, well above the expected run length
  always @(posedge sys_clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total++;
      final_report;
    end
  end

  initial begin
    {rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
     s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata,
     push_button_input_i, pll_locked_i, autowake_event_i, ext_irq_i,
     transfer_busy_event_i, one_second_event_i, fw_collision_a_event_i,
     fw_collision_b_event_i, watchdog_near_overflow_i, serial_port_irq_i,
     sleep_request_i, display_request_i, direct_brownout_wake_i} = '0;
    s_axi_wstrb = 4'hf;
    {err_total, tests_run, cyc_cnt} = '0;
    seed = 32'hfc39_6573;
    cyc(20);
    rst_b_i <= 1'b1;
    cyc(3);
    // --------
    // Reset values and refusals
    // --------
    foreach (regs[i]) rc(regs[i], 32'h0000_0000, RESP_OKAY);
    rc(16'h0010, 32'h0000_0000, RESP_SLVERR);
    wr(LEVEL_REG_ADDR, 8'hff, RESP_SLVERR);
    // --------
    // Autowake, mask and sticky status
    // --------
    wr(MASK_REG_ADDR, 8'h20, RESP_OKAY);
    rc(MASK_REG_ADDR, 32'h0000_0020, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      autowake_event_i <= 1'b1;
      cyc(1);
      autowake_event_i <= 1'b0;
      cyc(3);
      chk("irq", 32'(irq_o), 32'(i == 0));
      rc(FLAG_REG_ADDR, bit_of(WAKE_BIT), RESP_OKAY);
      rc(STATUS_REG_ADDR, bit_of(WAKE_BIT), RESP_OKAY);
      rc(STATUS_REG_ADDR, 32'h0000_0000, RESP_OKAY);
      chk("irq", 32'(irq_o), 32'h0000_0000);
      wr(FLAG_REG_ADDR, 8'h00, RESP_OKAY);
      rc(FLAG_REG_ADDR, 32'h0000_0000, RESP_OKAY);
      wr(MASK_REG_ADDR, 8'h00, RESP_OKAY);
    end
    // --------
    // Live input levels
    // --------
    repeat (4) begin
      lv = 7'($random(seed));
      ext_irq_i <= lv;
      cyc(4);
      rc(LEVEL_REG_ADDR, 32'(lv), RESP_OKAY);
    end
    // --------
    // Push button
    // --------
    push_button_input_i <= 1'b1;
    cyc(6);
    rc(FLAG_REG_ADDR, bit_of(BTN_BIT), RESP_OKAY);
    rc(FLAG_REG_ADDR, bit_of(BTN_BIT), RESP_OKAY);
    wr(FLAG_REG_ADDR, 8'h00, RESP_OKAY);
    rc(FLAG_REG_ADDR, 32'h0000_0000, RESP_OKAY);
    push_button_input_i <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      cyc(3);
      push_button_input_i <= 1'b1;
      cyc(6);
      {display_request_i, sleep_request_i} <= 2'(1 << i);
      cyc(1);
      {display_request_i, sleep_request_i} <= 2'b00;
      push_button_input_i <= 1'b0;
      rc(FLAG_REG_ADDR, 32'h0000_0000, RESP_OKAY);
    end
    // --------
    // Power good edges
    // --------
    pll_locked_i <= 1'b1;
    cyc(6);
    rc(FLAG_REG_ADDR, bit_of(RISE_BIT), RESP_OKAY);
    chk("power_line", 32'(power_interrupt_line_o), 32'h0000_0001);
    wr(FLAG_REG_ADDR, 8'h00, RESP_OKAY);
    pll_locked_i <= 1'b0;
    cyc(6);
    rc(FLAG_REG_ADDR, bit_of(FALL_BIT), RESP_OKAY);
    chk("brownout", 32'(brownout_request_o), 32'h0000_0001);
    wr(FLAG_REG_ADDR, 8'h00, RESP_OKAY);
    rc(FLAG_REG_ADDR, 32'h0000_0000, RESP_OKAY);
    direct_brownout_wake_i <= 1'b1;
    pll_locked_i <= 1'b1;
    cyc(6);
    pll_locked_i <= 1'b0;
    cyc(6);
    rc(FLAG_REG_ADDR, bit_of(RISE_BIT), RESP_OKAY);
    wr(FLAG_REG_ADDR, 8'h00, RESP_OKAY);
    direct_brownout_wake_i <= 1'b0;
    // --------
    // Self-clearing and collision flags
    // --------
    for (int i = 0; i < 2; i++) begin
      {one_second_event_i, transfer_busy_event_i} <= 2'(1 << i);
      cyc(3);
      rc(FLAG_REG_ADDR, bit_of(i), RESP_OKAY);
      {one_second_event_i, transfer_busy_event_i} <= 2'b00;
      cyc(3);
      rc(FLAG_REG_ADDR, 32'h0000_0000, RESP_OKAY);
      {fw_collision_b_event_i, fw_collision_a_event_i} <= 2'(1 << i);
      cyc(1);
      {fw_collision_b_event_i, fw_collision_a_event_i} <= 2'b00;
      rc(FLAG_REG_ADDR, bit_of(COLA_BIT + i), RESP_OKAY);
      wv = 8'($random(seed)) & 8'h0c;
      wr(FLAG_REG_ADDR, wv, RESP_OKAY);
      rc(FLAG_REG_ADDR, 32'(wv), RESP_OKAY);
      wr(FLAG_REG_ADDR, 8'h00, RESP_OKAY);
    end
    // --------
    // Enables gate the level sources
    // --------
    wv = 8'($random(seed));
    wr(ENABLE_REG_ADDR, wv, RESP_OKAY);
    rc(ENABLE_REG_ADDR, 32'(wv), RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      wr(ENABLE_REG_ADDR, i ? 8'h10 : 8'h01, RESP_OKAY);
      {serial_port_irq_i, watchdog_near_overflow_i} <= 2'(1 << i);
      cyc(3);
      chk("core_irq", 32'(core_irq_o), 32'h0000_0001);
      wr(ENABLE_REG_ADDR, i ? 8'h01 : 8'h10, RESP_OKAY);
      cyc(3);
      chk("core_irq", 32'(core_irq_o), 32'h0000_0000);
      {serial_port_irq_i, watchdog_near_overflow_i} <= 2'b00;
    end
    final_report;
  end
endmodule // wake_and_interrupt_flags_tb_top

`default_nettype wire
